// File: dv/asp_checker.sv
`timescale 1ns/10ps
`include "asp_defs.svh"
// ----------------------------------------------------------------
// Port-level checks
// ----------------------------------------------------------------
module asp_checker (
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	input  wire asp_pkg::asp_apb_req_t apb_i,
	input  wire asp_pkg::asp_apb_rsp_t apb_o,
	input  wire logic                  serial_in_i,
	input  wire logic                  serial_out_o,
	input  wire logic                  irq_o
);
	logic [3:0] run_reg;
	logic       last_reg;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	function automatic logic mapped(input logic [11:0] a);
		return a inside {`ASP_OFF_DATA, `ASP_OFF_RSTAT, `ASP_OFF_FLAG, [`ASP_OFF_LPDIV:`ASP_OFF_ICLEAR]}
			&& a[1:0] == 2'h0;
	endfunction

	// Shortest legal level run is an infrared pulse of three clocks
	always_ff @(posedge clk_i) begin
		last_reg <= serial_out_o;
		if (!rst_b_i || serial_out_o != last_reg)
			run_reg <= 4'h1;
		else if (run_reg != 4'hf)
			run_reg <= run_reg + 4'h1;
	end

	pready_pulse_a: assert property (apb_o.pready |=> !apb_o.pready)
		else $error("pready held longer than one cycle");
	pready_wait_a: assert property (apb_o.pready |-> apb_i.psel && apb_i.penable
		&& $past(apb_i.psel && !apb_i.penable, 2)) else $error("pready not two edges after setup");
	slverr_only_a: assert property (apb_o.pslverr |-> apb_o.pready)
		else $error("pslverr without pready");
	slverr_map_a: assert property (apb_o.pready |-> apb_o.pslverr == !mapped(apb_i.paddr))
		else $error("pslverr disagrees with address map");
	unmapped_zero_a: assert property (apb_o.pready && apb_o.pslverr && !apb_i.pwrite
		|-> apb_o.prdata == 32'h0) else $error("unmapped read not zero");
	data_width_a: assert property (apb_o.pready && !apb_i.pwrite && apb_i.paddr == `ASP_OFF_DATA
		|-> apb_o.prdata[31:12] == 20'h0) else $error("data word wider than twelve bits");
	iclear_zero_a: assert property (apb_o.pready && !apb_i.pwrite && apb_i.paddr == `ASP_OFF_ICLEAR
		|-> apb_o.prdata == 32'h0) else $error("clear register reads nonzero");
	reset_idle_a: assert property ($rose(rst_b_i) |-> serial_out_o && !irq_o && !apb_o.pready)
		else $error("outputs not idle after reset");
	line_run_a: assert property ($changed(serial_out_o) |-> run_reg >= 4'h3)
		else $error("serial output level run too short");

	cover property (apb_o.pready && apb_i.pwrite);
	cover property (apb_o.pslverr);
	cover property ($rose(irq_o));
	cover property ($fell(serial_out_o));
endmodule

bind asp_top asp_checker asp_checker_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .apb_i(apb_i),
	.apb_o(apb_o), .serial_in_i(serial_in_i), .serial_out_o(serial_out_o), .irq_o(irq_o));

// File: dv/asp_remote.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Remote port: 16 clocks a bit, line pulled high when idle
// ----------------------------------------------------------------
module asp_remote (
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      line_o,
	output logic [8:0] got_o,
	output int        n_got_o
);
	initial begin
		line_o = 1'b1;
		n_got_o = 0;
	end

	// Eight data bits plus one more: parity when on, else first stop
	always begin
		@(negedge line_i);
		repeat (8) @(posedge clk_i);
		for (int i = 0; i < 9; i++) begin
			repeat (16) @(posedge clk_i);
			got_o[i] = line_i;
		end
		n_got_o++;
	end

	// Caller never sends while the device transmits
	task automatic send(input logic [10:0] f);
		for (int i = 0; i < 11; i++) begin
			line_o <= f[i];
			repeat (16) @(posedge clk_i);
		end
		line_o <= 1'b1;
	endtask
endmodule

// File: dv/test_async_serial_port_with_ir_codec.sv
`timescale 1ns/10ps
`include "asp_defs.svh"
module test_async_serial_port_with_ir_codec;
	logic                  clk_i = 1'b0;
	logic                  rst_b_i = 1'b0;
	asp_pkg::asp_apb_req_t req = '0;
	asp_pkg::asp_apb_rsp_t rsp;
	logic                  sin;
	logic                  sout;
	logic                  irq;
	logic [8:0]            got;
	logic [31:0]           r;
	logic                  e;
	int                    n_got;
	int                    n_mismatch = 0;
	int                    n_checks = 0;
	int                    cyc = 0;
	int                    hi = 0;

	always #5 clk_i = ~clk_i;

	asp_top #(.DEPTH(16)) asp_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .apb_i(req),
		.apb_o(rsp), .serial_in_i(sin), .serial_out_o(sout), .irq_o(irq));
	asp_remote asp_remote_inst (.clk_i(clk_i), .line_i(sout), .line_o(sin), .got_o(got),
		.n_got_o(n_got));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc++;
		hi += (sout === 1'b1);
		if (cyc == 50000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, x, s);
		end
	endtask

	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
		@(posedge clk_i);
		req.penable <= 1'b1;
		do @(posedge clk_i); while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
		bus(a, 1'b0, 32'h0);
		chk(nm, r, x);
	endtask

	// Waits on the busy flag; a hang is cut by the cycle ceiling
	task automatic idle();
		do bus(`ASP_OFF_FLAG, 1'b0, 32'h0); while (r[3] === 1'b1);
	endtask

	task automatic cfg(input logic [7:0] lc, input logic [9:0] ct);
		wr(`ASP_OFF_CTRL, 32'h300);
		wr(`ASP_OFF_LINE, {24'h0, lc});
		wr(`ASP_OFF_CTRL, {22'h0, ct});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd(`ASP_OFF_CTRL, 32'h300, "ctrl");
		rd(`ASP_OFF_THRESH, 32'h12, "thresh");
		rd(`ASP_OFF_FLAG, 32'h90, "flag");
		rd(`ASP_OFF_RAW, 32'h20, "raw");
		rd(12'h008, 32'h0, "unmapped");
		chk("slverr", e, 32'h1);
		chk("idle line", sout, 32'h1);
	endtask

	task automatic t_tx();
		wr(`ASP_OFF_IDIV, 32'h1);
		wr(`ASP_OFF_FDIV, 32'hff);
		rd(`ASP_OFF_FDIV, 32'h3f, "fraction");
		wr(`ASP_OFF_FDIV, 32'h0);
		cfg(8'h60, 10'h301);
		// Staged only: bits must stay at sixteen clocks
		wr(`ASP_OFF_IDIV, 32'h2);
		wr(`ASP_OFF_DATA, 32'ha5);
		bus(`ASP_OFF_FLAG, 1'b0, 32'h0);
		chk("busy", r[3], 32'h1);
		idle();
		chk("tx char", got, 32'h1a5);
		wr(`ASP_OFF_IDIV, 32'h1);
	endtask

	task automatic t_rx();
		logic [10:0] fr [4] = '{11'h478, 11'h678, 11'h078, 11'h000};
		logic [31:0] ex [4] = '{32'h03c, 32'h23c, 32'h13c, 32'h500};
		cfg(8'h66, 10'h301);
		wr(`ASP_OFF_DATA, 32'h07);
		idle();
		chk("tx parity", got, 32'h107);
		for (int i = 0; i < 4; i++) begin
			asp_remote_inst.send(fr[i]);
			repeat (8) @(posedge clk_i);
			rd(`ASP_OFF_DATA, ex[i], "rx word");
		end
	endtask

	task automatic t_irq();
		wr(`ASP_OFF_IMASK, 32'h10);
		asp_remote_inst.send(11'h422);
		repeat (8) @(posedge clk_i);
		chk("irq set", irq, 32'h1);
		rd(`ASP_OFF_MASKED, 32'h10, "masked");
		wr(`ASP_OFF_ICLEAR, 32'h10);
		bus(`ASP_OFF_RAW, 1'b0, 32'h0);
		chk("raw rx", r[4], 32'h0);
		chk("irq clear", irq, 32'h0);
		rd(`ASP_OFF_DATA, 32'h011, "rx word");
		wr(`ASP_OFF_IMASK, 32'h0);
	endtask

	task automatic t_loop();
		cfg(8'h66, 10'h381);
		wr(`ASP_OFF_DATA, 32'h5a);
		idle();
		repeat (20) @(posedge clk_i);
		rd(`ASP_OFF_DATA, 32'h05a, "loopback");
	endtask

	task automatic t_fifo();
		int n;
		cfg(8'h70, 10'h300);
		for (int i = 0; i < 16; i++)
			wr(`ASP_OFF_DATA, i);
		rd(`ASP_OFF_FLAG, 32'h38, "full flag");
		bus(`ASP_OFF_RAW, 1'b0, 32'h0);
		chk("tx event above", r[5], 32'h0);
		n = n_got;
		wr(`ASP_OFF_CTRL, 32'h301);
		idle();
		chk("drained", n_got - n, 32'd16);
		chk("last char", got, 32'h10f);
		bus(`ASP_OFF_RAW, 1'b0, 32'h0);
		chk("tx event below", r[5], 32'h1);
	endtask

	task automatic t_ir();
		logic [9:0] ct [2] = '{10'h303, 10'h307};
		int hx [2] = '{27, 54};
		wr(`ASP_OFF_LPDIV, 32'h2);
		for (int i = 0; i < 2; i++) begin
			cfg(8'h60, ct[i]);
			wr(`ASP_OFF_DATA, 32'h00);
			// Cleared only once the line sits at the low infrared idle level
			hi = 0;
			idle();
			chk("ir high time", hi, hx[i]);
			chk("ir idle", sout, 32'h0);
		end
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		rst_b_i <= 1'b1;
		t_reset();
		t_tx();
		t_rx();
		t_irq();
		t_loop();
		t_fifo();
		t_ir();
		finish_test();
	end
endmodule

// File: hdl/asp_defs.svh
// Functional notes
// - Send start, data LSB first, parity, stops
// - Check overrun, parity, framing, break per character
// - Divisor is 16-bit integer plus 6-bit fraction
// - Divisor makes 16x tick; sixteen ticks per bit
// - Divisors and line control latch on line write
// - Keep sending until transmit queue is empty
// - Busy until queue empty and stop bits sent
// - Start edge confirmed low on eighth tick
// - Sample data every sixteen ticks, then parity
// - Low stop is framing error; push with flags
// - Infrared: zero as 3/16 high pulse
// - Low-power infrared pulse is three reference ticks
// - Two 16-entry queues; 12-bit read, 8-bit write
// - Queues one deep until queue enable set
// - Empty and full flags; overrun status bit
// - Thresholds eighth to seven eighths, default half
// - Masked events ORed into one request
// - Writing one to clear drops raw and masked
// - Receive event by threshold or filled holding
// - Transmit event by threshold or empty holding
// - Loopback routes transmit back to receive
// - Both directions enabled; disable finishes character
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ASP_OFF_DATA     12'h000
`define ASP_OFF_RSTAT    12'h004
`define ASP_OFF_FLAG     12'h018
`define ASP_OFF_LPDIV    12'h020
`define ASP_OFF_IDIV     12'h024
`define ASP_OFF_FDIV     12'h028
`define ASP_OFF_LINE     12'h02c
`define ASP_OFF_CTRL     12'h030
`define ASP_OFF_THRESH   12'h034
`define ASP_OFF_IMASK    12'h038
`define ASP_OFF_RAW      12'h03c
`define ASP_OFF_MASKED   12'h040
`define ASP_OFF_ICLEAR   12'h044
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ASP_LC_BREAK     0
`define ASP_LC_PAR_EN    1
`define ASP_LC_PAR_EVEN  2
`define ASP_LC_STOP2     3
`define ASP_LC_QEN       4
`define ASP_LC_STICK     7
`define ASP_CT_EN        0
`define ASP_CT_IR        1
`define ASP_CT_IR_LP     2
`define ASP_CT_LOOP      7
`define ASP_CT_TXE       8
`define ASP_CT_RXE       9
`define ASP_IRQ_RX       4
`define ASP_IRQ_TX       5
`define ASP_IRQ_FRM      7
`define ASP_IRQ_PAR      8
`define ASP_IRQ_BRK      9
`define ASP_IRQ_OVR      10
`define ASP_IRQ_WMASK    11'h7f0
// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define ASP_CTRL_RST     10'h300
`define ASP_THRESH_RST   6'h12
`define ASP_TICK_LAST    4'hf
`define ASP_START_CHECK  4'h7
`define ASP_IR_PULSE     4'h3
`define ASP_LP_PULSE     2'h3
`define ASP_DIV_STEP     23'd64
`endif

// File: hdl/asp_pkg.sv
package asp_pkg;
	typedef struct packed {
		logic [11:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} asp_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} asp_apb_rsp_t;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} asp_tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} asp_rx_state_t;
endpackage

// File: hdl/asp_top.sv
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
`include "asp_defs.svh"
module asp_top #(
	parameter int DEPTH = 16
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	input  wire asp_pkg::asp_apb_req_t apb_i,
	output asp_pkg::asp_apb_rsp_t      apb_o,
	input  wire logic                  serial_in_i,
	output logic                       serial_out_o,
	output logic                       irq_o
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;

	typedef struct packed {
		logic [15:0]                 idiv;
		logic [5:0]                  fdiv;
		logic [29:0]                 active;
		logic [9:0]                  ctrl;
		logic [5:0]                  thresh;
		logic [10:0]                 imask;
		logic [10:0]                 raw;
		logic [7:0]                  lpdiv;
		logic [3:0]                  rstat;
		logic                        rx_cond_q;
		logic                        tx_cond_q;
		logic [22:0]                 acc;
		logic [7:0]                  lpcnt;
		asp_pkg::asp_tx_state_t      tx_st;
		logic [3:0]                  tx_sub;
		logic [2:0]                  tx_bit;
		logic [7:0]                  tx_sh;
		logic                        tx_par;
		logic                        tx_stop2;
		logic [1:0]                  ir_lp;
		asp_pkg::asp_rx_state_t      rx_st;
		logic [3:0]                  rx_sub;
		logic [2:0]                  rx_bit;
		logic [7:0]                  rx_sh;
		logic                        rx_perr;
		logic                        rx_zero;
		logic                        rx_prev;
		logic                        ovr_pend;
		logic [4:0]                  ir_stretch;
		logic [DEPTH-1:0][7:0]       txq;
		logic [PW-1:0]               tx_wp;
		logic [PW-1:0]               tx_rp;
		logic [CW-1:0]               tx_cnt;
		logic [DEPTH-1:0][11:0]      rxq;
		logic [PW-1:0]               rx_wp;
		logic [PW-1:0]               rx_rp;
		logic [CW-1:0]               rx_cnt;
		logic                        ack;
		logic                        err;
		logic [31:0]                 prdata;
		logic                        serial_out;
	} asp_state_t;

	asp_state_t  state_reg;
	asp_state_t  state_next;

	logic        rd_done;
	logic        wr_done;
	logic [31:0] rdata;
	logic        mapped;
	logic        tick;
	logic        lptick;
	logic [22:0] acc_sum;
	logic [7:0]  lc;
	logic        qen;
	logic [CW-1:0] cap;
	logic [2:0]  last_bit;
	logic        tx_line;
	logic        rx_line;
	logic        ir_dec;
	logic        port_on;
	logic        busy;
	logic        tx_push;
	logic        tx_pop;
	logic        rx_push;
	logic        rx_pop;
	logic [11:0] rx_word;
	logic [7:0]  rx_data;
	logic        rx_cond;
	logic        tx_cond;
	logic [CW-1:0] rx_lvl;
	logic [CW-1:0] tx_lvl;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic par_of(input logic [7:0] d, input logic [2:0] lb,
	                                input logic even, input logic stick);
		logic [7:0] m;
		logic       p;
		m = 8'hff >> (3'd7 - lb);
		p = ^(d & m);
		if (stick) begin
			par_of = ~even;
		end else begin
			par_of = even ? p : ~p;
		end
	endfunction

	function automatic logic [CW-1:0] level_of(input logic [2:0] sel);
		case (sel)
			3'h0:    level_of = CW'(DEPTH / 8);
			3'h1:    level_of = CW'(DEPTH / 4);
			3'h3:    level_of = CW'(3 * DEPTH / 4);
			3'h4:    level_of = CW'(7 * DEPTH / 8);
			default: level_of = CW'(DEPTH / 2);
		endcase
	endfunction

	always_comb begin
		lc       = state_reg.active[7:0];
		qen      = lc[`ASP_LC_QEN];
		cap      = qen ? CW'(DEPTH) : CW'(1);
		last_bit = 3'h4 + {1'b0, lc[6:5]};
		port_on  = state_reg.ctrl[`ASP_CT_EN];
		busy     = (state_reg.tx_cnt != '0) || (state_reg.tx_st != asp_pkg::TX_IDLE);
		rx_lvl   = level_of(state_reg.thresh[5:3]);
		tx_lvl   = level_of(state_reg.thresh[2:0]);
		rx_word  = state_reg.rxq[state_reg.rx_rp];
		rx_data  = state_reg.rx_sh >> (3'd7 - last_bit);
		// Divisor in 1/64 steps: add 64 per clock, tick when it reaches the divisor
		acc_sum  = state_reg.acc + `ASP_DIV_STEP;
		tick     = acc_sum >= {1'b0, state_reg.active[29:8]};
		lptick   = state_reg.lpcnt == 8'h00;
		case (state_reg.tx_st)
			asp_pkg::TX_START:  tx_line = 1'b0;
			asp_pkg::TX_DATA:   tx_line = state_reg.tx_sh[0];
			asp_pkg::TX_PARITY: tx_line = state_reg.tx_par;
			default:            tx_line = 1'b1;
		endcase
		if (lc[`ASP_LC_BREAK]) begin
			tx_line = 1'b0;
		end
		// Stretched decoder: a short light pulse holds a zero for one bit time
		ir_dec = (state_reg.ir_stretch == 5'h00) && serial_in_i;
		if (state_reg.ctrl[`ASP_CT_LOOP]) begin
			rx_line = tx_line;
		end else if (state_reg.ctrl[`ASP_CT_IR]) begin
			rx_line = ir_dec;
		end else begin
			rx_line = serial_in_i;
		end
		rx_cond = qen ? (state_reg.rx_cnt >= rx_lvl) : (state_reg.rx_cnt != '0);
		tx_cond = qen ? (state_reg.tx_cnt <= tx_lvl) : (state_reg.tx_cnt == '0);
	end

	// ----------------------------------------------------------------
	// Register read mux
	// ----------------------------------------------------------------
	always_comb begin
		rdata  = 32'h0000_0000;
		mapped = 1'b1;
		case (apb_i.paddr)
			`ASP_OFF_DATA:   rdata = {20'h00000, rx_word};
			`ASP_OFF_RSTAT:  rdata = {28'h0000000, state_reg.rstat};
			`ASP_OFF_FLAG:   rdata = {24'h000000,
			                          state_reg.tx_cnt == '0,
			                          state_reg.rx_cnt >= cap,
			                          state_reg.tx_cnt >= cap,
			                          state_reg.rx_cnt == '0,
			                          busy, 3'h0};
			`ASP_OFF_LPDIV:  rdata = {24'h000000, state_reg.lpdiv};
			`ASP_OFF_IDIV:   rdata = {16'h0000, state_reg.idiv};
			`ASP_OFF_FDIV:   rdata = {26'h0000000, state_reg.fdiv};
			`ASP_OFF_LINE:   rdata = {24'h000000, lc};
			`ASP_OFF_CTRL:   rdata = {22'h000000, state_reg.ctrl};
			`ASP_OFF_THRESH: rdata = {26'h0000000, state_reg.thresh};
			`ASP_OFF_IMASK:  rdata = {21'h000000, state_reg.imask};
			`ASP_OFF_RAW:    rdata = {21'h000000, state_reg.raw};
			`ASP_OFF_MASKED: rdata = {21'h000000, state_reg.raw & state_reg.imask};
			`ASP_OFF_ICLEAR: rdata = 32'h0000_0000;
			default:         mapped = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		tx_push    = 1'b0;
		tx_pop     = 1'b0;
		rx_push    = 1'b0;
		rx_pop     = 1'b0;

		// One wait state: data is latched in the first access cycle
		rd_done = apb_i.psel && apb_i.penable && state_reg.ack && !apb_i.pwrite;
		wr_done = apb_i.psel && apb_i.penable && state_reg.ack && apb_i.pwrite;
		state_next.ack = apb_i.psel && apb_i.penable && !state_reg.ack;
		if (state_next.ack) begin
			state_next.prdata = apb_i.pwrite ? 32'h0000_0000 : rdata;
			state_next.err    = !mapped;
		end

		// Baud and low-power reference generators
		state_next.acc   = tick ? acc_sum - {1'b0, state_reg.active[29:8]} : acc_sum;
		state_next.lpcnt = lptick ? state_reg.lpdiv - 8'h01 : state_reg.lpcnt - 8'h01;

		// Interrupt clear first, so that a same-cycle event below wins
		if (wr_done && apb_i.paddr == `ASP_OFF_ICLEAR) begin
			state_next.raw = state_reg.raw & ~apb_i.pwdata[10:0];
		end

		if (wr_done) begin
			case (apb_i.paddr)
				`ASP_OFF_DATA: begin
					tx_push = state_reg.tx_cnt < cap;
				end
				`ASP_OFF_RSTAT:  state_next.rstat  = 4'h0;
				`ASP_OFF_LPDIV:  state_next.lpdiv  = apb_i.pwdata[7:0];
				`ASP_OFF_IDIV:   state_next.idiv   = apb_i.pwdata[15:0];
				`ASP_OFF_FDIV:   state_next.fdiv   = apb_i.pwdata[5:0];
				// Divisors only reach the generator through this write
				`ASP_OFF_LINE:   state_next.active = {state_reg.idiv, state_reg.fdiv,
				                                      apb_i.pwdata[7:0]};
				`ASP_OFF_CTRL:   state_next.ctrl   = apb_i.pwdata[9:0];
				`ASP_OFF_THRESH: state_next.thresh = apb_i.pwdata[5:0];
				`ASP_OFF_IMASK:  state_next.imask  = apb_i.pwdata[10:0] & `ASP_IRQ_WMASK;
				default: ;
			endcase
		end
		if (rd_done && apb_i.paddr == `ASP_OFF_DATA && state_reg.rx_cnt != '0) begin
			rx_pop = 1'b1;
			state_next.rstat[2:0] = rx_word[10:8];
		end

		// Transmitter
		case (state_reg.tx_st)
			asp_pkg::TX_IDLE: begin
				// Enable only gates the start of a new character
				if (state_reg.tx_cnt != '0 && port_on && state_reg.ctrl[`ASP_CT_TXE]) begin
					tx_pop              = 1'b1;
					state_next.tx_sh    = state_reg.txq[state_reg.tx_rp];
					state_next.tx_par   = par_of(state_reg.txq[state_reg.tx_rp], last_bit,
					                             lc[`ASP_LC_PAR_EVEN], lc[`ASP_LC_STICK]);
					state_next.tx_st    = asp_pkg::TX_START;
					state_next.tx_sub   = 4'h0;
					state_next.tx_stop2 = 1'b0;
				end
			end
			default: begin
				if (tick) begin
					state_next.tx_sub = state_reg.tx_sub + 4'h1;
					if (state_reg.tx_sub == `ASP_TICK_LAST) begin
						case (state_reg.tx_st)
							asp_pkg::TX_START: begin
								state_next.tx_st  = asp_pkg::TX_DATA;
								state_next.tx_bit = 3'h0;
							end
							asp_pkg::TX_DATA: begin
								state_next.tx_sh  = {1'b0, state_reg.tx_sh[7:1]};
								state_next.tx_bit = state_reg.tx_bit + 3'h1;
								if (state_reg.tx_bit == last_bit) begin
									state_next.tx_st = lc[`ASP_LC_PAR_EN] ?
									                   asp_pkg::TX_PARITY : asp_pkg::TX_STOP;
								end
							end
							asp_pkg::TX_PARITY: state_next.tx_st = asp_pkg::TX_STOP;
							default: begin
								if (lc[`ASP_LC_STOP2] && !state_reg.tx_stop2) begin
									state_next.tx_stop2 = 1'b1;
								end else begin
									state_next.tx_st = asp_pkg::TX_IDLE;
								end
							end
						endcase
					end
				end
			end
		endcase

		// Infrared encoder
		if (lptick && state_reg.ir_lp != 2'h0) begin
			state_next.ir_lp = state_reg.ir_lp - 2'h1;
		end
		if (tick && !tx_line && state_reg.tx_sub == 4'h0) begin
			state_next.ir_lp = `ASP_LP_PULSE;
			// Restart the reference so the pulse spans three whole periods
			state_next.lpcnt = state_reg.lpdiv - 8'h01;
		end
		if (!state_reg.ctrl[`ASP_CT_IR]) begin
			state_next.serial_out = tx_line;
		end else if (state_reg.ctrl[`ASP_CT_IR_LP]) begin
			state_next.serial_out = state_reg.ir_lp != 2'h0;
		end else begin
			state_next.serial_out = !tx_line && state_reg.tx_sub < `ASP_IR_PULSE;
		end

		// Infrared decoder stretch
		if (!serial_in_i) begin
			state_next.ir_stretch = 5'h10;
		end else if (tick && state_reg.ir_stretch != 5'h00) begin
			state_next.ir_stretch = state_reg.ir_stretch - 5'h01;
		end

		// Receiver
		state_next.rx_prev = rx_line;
		case (state_reg.rx_st)
			asp_pkg::RX_IDLE: begin
				if (port_on && state_reg.ctrl[`ASP_CT_RXE] && state_reg.rx_prev && !rx_line) begin
					state_next.rx_st   = asp_pkg::RX_START;
					state_next.rx_sub  = 4'h0;
					state_next.rx_zero = 1'b1;
					state_next.rx_perr = 1'b0;
				end
			end
			asp_pkg::RX_START: begin
				if (tick) begin
					state_next.rx_sub = state_reg.rx_sub + 4'h1;
					if (state_reg.rx_sub == `ASP_START_CHECK) begin
						state_next.rx_sub = 4'h0;
						state_next.rx_bit = 3'h0;
						state_next.rx_st  = rx_line ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
					end
				end
			end
			default: begin
				if (tick) begin
					state_next.rx_sub = state_reg.rx_sub + 4'h1;
					if (state_reg.rx_sub == `ASP_TICK_LAST) begin
						state_next.rx_zero = state_reg.rx_zero && !rx_line;
						case (state_reg.rx_st)
							asp_pkg::RX_DATA: begin
								state_next.rx_sh  = {rx_line, state_reg.rx_sh[7:1]};
								state_next.rx_bit = state_reg.rx_bit + 3'h1;
								if (state_reg.rx_bit == last_bit) begin
									state_next.rx_st = lc[`ASP_LC_PAR_EN] ?
									                   asp_pkg::RX_PARITY : asp_pkg::RX_STOP;
								end
							end
							asp_pkg::RX_PARITY: begin
								state_next.rx_perr = rx_line != par_of(rx_data, last_bit,
								                     lc[`ASP_LC_PAR_EVEN], lc[`ASP_LC_STICK]);
								state_next.rx_st   = asp_pkg::RX_STOP;
							end
							default: begin
								state_next.rx_st = asp_pkg::RX_IDLE;
								if (!rx_line) begin
									state_next.raw[`ASP_IRQ_FRM] = 1'b1;
								end
								if (state_reg.rx_zero && !rx_line) begin
									state_next.raw[`ASP_IRQ_BRK] = 1'b1;
								end
								if (state_reg.rx_perr) begin
									state_next.raw[`ASP_IRQ_PAR] = 1'b1;
								end
								if (state_reg.rx_cnt < cap || rx_pop) begin
									rx_push             = 1'b1;
									state_next.ovr_pend = 1'b0;
								end else begin
									state_next.ovr_pend          = 1'b1;
									state_next.rstat[3]          = 1'b1;
									state_next.raw[`ASP_IRQ_OVR] = 1'b1;
								end
							end
						endcase
					end
				end
			end
		endcase

		// Queues
		if (tx_push) begin
			state_next.txq[state_reg.tx_wp] = apb_i.pwdata[7:0];
			state_next.tx_wp = qen ? state_reg.tx_wp + PW'(1) : state_reg.tx_rp;
		end
		if (tx_pop) begin
			state_next.tx_rp = qen ? state_reg.tx_rp + PW'(1) : state_reg.tx_rp;
		end
		state_next.tx_cnt = state_reg.tx_cnt + CW'(tx_push) - CW'(tx_pop);
		if (rx_push) begin
			state_next.rxq[state_reg.rx_wp] = {state_reg.ovr_pend,
			                                   state_reg.rx_zero && !rx_line,
			                                   state_reg.rx_perr, !rx_line, rx_data};
			state_next.rx_wp = qen ? state_reg.rx_wp + PW'(1) : state_reg.rx_rp;
		end
		if (rx_pop) begin
			state_next.rx_rp = qen ? state_reg.rx_rp + PW'(1) : state_reg.rx_rp;
		end
		state_next.rx_cnt = state_reg.rx_cnt + CW'(rx_push) - CW'(rx_pop);

		// Queue level events: edge sets, condition fall or clear drops
		state_next.rx_cond_q = rx_cond;
		state_next.tx_cond_q = tx_cond;
		if (!rx_cond) begin
			state_next.raw[`ASP_IRQ_RX] = 1'b0;
		end
		if (rx_cond && !state_reg.rx_cond_q) begin
			state_next.raw[`ASP_IRQ_RX] = 1'b1;
		end
		if (!tx_cond) begin
			state_next.raw[`ASP_IRQ_TX] = 1'b0;
		end
		if (tx_cond && !state_reg.tx_cond_q) begin
			state_next.raw[`ASP_IRQ_TX] = 1'b1;
		end

		if (!rst_b_i) begin
			state_next            = '0;
			state_next.ctrl       = `ASP_CTRL_RST;
			state_next.thresh     = `ASP_THRESH_RST;
			state_next.rx_prev    = 1'b1;
			state_next.serial_out = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		state_reg <= state_next;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign serial_out_o  = state_reg.serial_out;
	assign irq_o         = |(state_reg.raw & state_reg.imask);
	assign apb_o.prdata  = state_reg.prdata;
	assign apb_o.pready  = state_reg.ack;
	assign apb_o.pslverr = state_reg.ack && state_reg.err;
endmodule
